// file: include/dcdic_map.svh
// Constants of the dual current converter input control: widths, offsets, fields, reset values.
`ifndef DCDIC_MAP_SVH
`define DCDIC_MAP_SVH
`define DCDIC_CODE_W 12
`define DCDIC_CODE_MAX 12'hfff
`define DCDIC_CODE_RST 12'h000
`define DCDIC_PAIR_W 24
`define DCDIC_FIFO_DEPTH 8
`define DCDIC_SEG_W 15
`define DCDIC_SEG_LSB 8
`define DCDIC_ADDR_W 8
`define DCDIC_DATA_W 32
`define DCDIC_OFF_CTRL 8'h00
`define DCDIC_OFF_STATUS 8'h04
`define DCDIC_OFF_OUTPUT 8'h08
`define DCDIC_OFF_LATCH 8'h0c
`define DCDIC_CTRL_HOLD_BIT 0
`define DCDIC_CTRL_RST 1'h0
`define DCDIC_ST_MODE_LSB 0
`define DCDIC_ST_MODE_MSB 4
`define DCDIC_ST_CSLAT_BIT 5
`define DCDIC_ST_OVF_BIT 6
`define DCDIC_ST_CNT_LSB 8
`define DCDIC_ST_CNT_MSB 11
`define DCDIC_LO_LSB 0
`define DCDIC_LO_MSB 11
`define DCDIC_HI_LSB 16
`define DCDIC_HI_MSB 27
`endif

// file: include/dcdic_pkg.sv
// Types shared by the dual current converter input control.
`include "dcdic_map.svh"
`default_nettype none
package dcdic_pkg;
   typedef enum logic [4:0] {
      DCDIC_FULL_PD = 5'h01,
      DCDIC_STANDBY_SELECT_RUN = 5'h02,
      DCDIC_STANDBY_SELECT_GATED = 5'h04,
      DCDIC_NORMAL = 5'h08,
      DCDIC_BUS_HOLD = 5'h10
   } dcdic_mode_t;
   typedef logic [`DCDIC_CODE_W-1:0] dcdic_code_t;
   typedef logic [`DCDIC_SEG_W-1:0] dcdic_seg_t;
   typedef struct packed {
      logic conv_prev;
      logic cs_lat;
      dcdic_code_t ch1_lat;
      dcdic_code_t ch2_lat;
      logic push_valid;
      logic [`DCDIC_PAIR_W-1:0] push_data;
      dcdic_code_t out1;
      dcdic_code_t out1_c;
      dcdic_code_t out2;
      dcdic_code_t out2_c;
      dcdic_seg_t seg1;
      dcdic_seg_t seg2;
      logic iout_en;
      logic vout_en;
      logic int_clk;
      dcdic_mode_t mode;
      logic hold;
      logic ovf;
      logic [`DCDIC_DATA_W-1:0] rdata;
   } dcdic_state_t;
endpackage
`default_nettype wire

// file: include/dcdic_fifo_if.sv
// Carrier between the input control and its pair FIFO.
`default_nettype none
interface dcdic_fifo_if #(parameter int W = 24, parameter int DEPTH = 8);
   localparam int CW = $clog2(DEPTH + 1);
   logic [W-1:0] in_data;
   logic in_valid;
   logic in_ready;
   logic [W-1:0] out_data;
   logic out_valid;
   logic out_ready;
   logic [CW-1:0] level;
   modport fifo (input in_data, input in_valid, input out_ready,
                 output in_ready, output out_data, output out_valid, output level);
   modport user (output in_data, output in_valid, output out_ready,
                 input in_ready, input out_data, input out_valid, input level);
endinterface
`default_nettype wire

// file: verilog/dcdic_fifo.sv
// Synchronous FIFO holding converter word pairs between capture and output update.
`default_nettype none
module dcdic_fifo #(
   parameter int W = 24,
   parameter int DEPTH = 8
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_ce,
   // Both sides of the queue
   dcdic_fifo_if.fifo bus
);
   localparam int PW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);
   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [PW-1:0] wp;
      logic [PW-1:0] rp;
      logic [CW-1:0] cnt;
   } dcdic_fifo_st_t;
   dcdic_fifo_st_t st_reg;
   dcdic_fifo_st_t st_next;
   logic push;
   logic pop;

   assign bus.in_ready = (st_reg.cnt != CW'(DEPTH));
   assign bus.out_valid = (st_reg.cnt != '0);
   assign bus.out_data = st_reg.mem[st_reg.rp];
   assign bus.level = st_reg.cnt;
   assign push = bus.in_valid && bus.in_ready;
   assign pop = bus.out_valid && bus.out_ready;

   always_comb begin
      st_next = st_reg;
      if (push) begin
         st_next.mem[st_reg.wp] = bus.in_data;
         st_next.wp = st_reg.wp + 1'b1;
      end
      if (pop) begin
         st_next.rp = st_reg.rp + 1'b1;
      end
      case ({push, pop})
         2'b10: st_next.cnt = st_reg.cnt + 1'b1;
         2'b01: st_next.cnt = st_reg.cnt - 1'b1;
         default: st_next.cnt = st_reg.cnt;
      endcase
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         st_reg <= '0;
      end else if (i_ce) begin
         st_reg <= st_next;
      end
   end
endmodule
`default_nettype wire

// file: verilog/dcdic_top.sv
// Input control of a dual 12-bit current-output converter: capture, chip select, modes, outputs.
//
// Behaviour
// - Codes are unsigned 0..4095; complement output carries 4095 minus code.
// - Edge latches plus a segment decoder refreshed on every output update.
// - Full power-down tristates outputs; standby and select then have no effect.
// - Power-down, standby and select low: standby, tristate, words still captured.
// - In standby the outputs are not refreshed from newly captured words.
// - Standby with select high gates the internal clock; nothing is captured.
// - Standby high, select low is normal operation, resuming the pre-standby output.
// - Standby high and select high ignores data and clock, holding outputs.
// - Voltage power-down tristates the voltage section independently of the rest.
// - Unconnected mode pins default to levels giving fully operational converters.
// - With power-down and select low the internal clock follows the conversion clock.
// - Channel 1 is taken on rising edges, channel 2 on falling edges.
// - Each rising edge moves the previously captured pair to both outputs together.
// - Select rising acts at the next rising edge; internal clock then held high.
// - Select low registers at a rising edge; first capture is channel 2.
// - Next rising edge outputs stale channel 1 with new channel 2, captures channel 1.
//
// The register offsets and the address-and-strobe port were decided locally.
`include "dcdic_map.svh"
`default_nettype none
module dcdic_top (
   // Clock, reset and clock enable
   input wire logic I_CLK,
   input wire logic I_RST,
   input wire logic I_CE,
   // Conversion clock and parallel data port
   input wire logic I_CONV_CLK,
   input wire logic [`DCDIC_CODE_W-1:0] I_DATA,
   // Mode pins
   input wire logic I_FULL_POWER_DOWN,
   input wire logic I_STANDBY_SELECT,
   input wire logic I_DEVICE_SELECT_N,
   input wire logic I_VOLTAGE_DAC_POWER_DOWN,
   // Register port
   input wire logic [`DCDIC_ADDR_W-1:0] I_ADDR,
   input wire logic [`DCDIC_DATA_W-1:0] I_WDATA,
   input wire logic I_WR,
   input wire logic I_RD,
   output logic [`DCDIC_DATA_W-1:0] O_RDATA,
   // Converter codes and switch drive
   output logic [`DCDIC_CODE_W-1:0] O_IOUT1,
   output logic [`DCDIC_CODE_W-1:0] O_IOUT1_C,
   output logic [`DCDIC_CODE_W-1:0] O_IOUT2,
   output logic [`DCDIC_CODE_W-1:0] O_IOUT2_C,
   output logic [`DCDIC_SEG_W-1:0] O_SEG1,
   output logic [`DCDIC_SEG_W-1:0] O_SEG2,
   // Output enables, internal clock and mode
   output logic O_IOUT_EN,
   output logic O_VOUT_EN,
   output logic O_INT_CLK,
   output logic [4:0] O_MODE
);
   dcdic_pkg::dcdic_state_t st_reg;
   dcdic_pkg::dcdic_state_t st_next;
   dcdic_fifo_if #(.W(`DCDIC_PAIR_W), .DEPTH(`DCDIC_FIFO_DEPTH)) pair_q ();
   logic conv_rise;
   logic conv_fall;
   logic clk_run;
   logic standby;
   logic [`DCDIC_CODE_W-1:0] q_ch1;
   logic [`DCDIC_CODE_W-1:0] q_ch2;

   // Complement code for the complementary current output of both channels.
   function automatic dcdic_pkg::dcdic_code_t comp_code(input dcdic_pkg::dcdic_code_t code);
      comp_code = `DCDIC_CODE_MAX - code;
   endfunction

   // Thermometer decode of the upper nibble drives the unary current segments.
   function automatic dcdic_pkg::dcdic_seg_t seg_decode(input dcdic_pkg::dcdic_code_t code);
      dcdic_pkg::dcdic_seg_t s;
      s = '0;
      for (int k = 0; k < `DCDIC_SEG_W; k++) begin
         s[k] = (32'(code[`DCDIC_CODE_W-1:`DCDIC_SEG_LSB]) > k);
      end
      seg_decode = s;
   endfunction

   // Mode decode from the pin levels; the select pin is taken as presented.
   function automatic dcdic_pkg::dcdic_mode_t mode_decode(input logic pd, input logic sb, input logic cs_n);
      if (pd) begin
         mode_decode = dcdic_pkg::DCDIC_FULL_PD;
      end else if (!sb && !cs_n) begin
         mode_decode = dcdic_pkg::DCDIC_STANDBY_SELECT_RUN;
      end else if (!sb) begin
         mode_decode = dcdic_pkg::DCDIC_STANDBY_SELECT_GATED;
      end else if (!cs_n) begin
         mode_decode = dcdic_pkg::DCDIC_NORMAL;
      end else begin
         mode_decode = dcdic_pkg::DCDIC_BUS_HOLD;
      end
   endfunction

   dcdic_fifo #(.W(`DCDIC_PAIR_W), .DEPTH(`DCDIC_FIFO_DEPTH)) u_pair_fifo (
      .i_clk(I_CLK),
      .i_rst(I_RST),
      .i_ce(I_CE),
      .bus(pair_q.fifo)
   );

   // The conversion clock is sampled as a level; an edge acts at the first system clock that samples the new level.
   assign conv_rise = I_CONV_CLK && !st_reg.conv_prev;
   assign conv_fall = !I_CONV_CLK && st_reg.conv_prev;
   assign clk_run = !I_FULL_POWER_DOWN && !st_reg.cs_lat;
   assign standby = !I_FULL_POWER_DOWN && !I_STANDBY_SELECT;
   assign q_ch1 = pair_q.out_data[`DCDIC_HI_MSB-`DCDIC_HI_LSB+`DCDIC_CODE_W:`DCDIC_CODE_W];
   assign q_ch2 = pair_q.out_data[`DCDIC_CODE_W-1:0];
   assign pair_q.in_data = st_reg.push_data;
   assign pair_q.in_valid = st_reg.push_valid;
   assign pair_q.out_ready = !st_reg.hold && !standby && !I_FULL_POWER_DOWN;

   always_comb begin
      st_next = st_reg;
      st_next.conv_prev = I_CONV_CLK;
      st_next.push_valid = 1'b0;
      st_next.rdata = '0;

      st_next.int_clk = clk_run ? I_CONV_CLK : 1'b1;

      if (conv_rise) begin
         st_next.cs_lat = I_DEVICE_SELECT_N;
         if (clk_run) begin
            // Stale channel 1 pairs new channel 2.
            if (!standby) begin
               st_next.push_valid = 1'b1;
               st_next.push_data = {st_reg.ch1_lat, st_reg.ch2_lat};
            end
            st_next.ch1_lat = I_DATA;
         end
      end
      if (conv_fall && clk_run) begin
         st_next.ch2_lat = I_DATA;
      end

      if (pair_q.out_valid && pair_q.out_ready) begin
         st_next.out1 = q_ch1;
         st_next.out1_c = comp_code(q_ch1);
         st_next.out2 = q_ch2;
         st_next.out2_c = comp_code(q_ch2);
         st_next.seg1 = seg_decode(q_ch1);
         st_next.seg2 = seg_decode(q_ch2);
      end

      // Pins assumed pulled to operating levels.
      st_next.mode = mode_decode(I_FULL_POWER_DOWN, I_STANDBY_SELECT, I_DEVICE_SELECT_N);
      st_next.iout_en = (st_next.mode == dcdic_pkg::DCDIC_NORMAL) ||
                        (st_next.mode == dcdic_pkg::DCDIC_BUS_HOLD);
      st_next.vout_en = !I_VOLTAGE_DAC_POWER_DOWN && !I_FULL_POWER_DOWN;

      // A pair offered while the queue is full is lost; the sticky flag tells software.
      if (I_WR && (I_ADDR == `DCDIC_OFF_CTRL)) begin
         st_next.hold = I_WDATA[`DCDIC_CTRL_HOLD_BIT];
      end
      if (I_WR && (I_ADDR == `DCDIC_OFF_STATUS) && I_WDATA[`DCDIC_ST_OVF_BIT]) begin
         st_next.ovf = 1'b0;
      end
      if (st_reg.push_valid && !pair_q.in_ready) begin
         st_next.ovf = 1'b1;
      end

      if (I_RD) begin
         case (I_ADDR)
            `DCDIC_OFF_CTRL: begin
               st_next.rdata[`DCDIC_CTRL_HOLD_BIT] = st_reg.hold;
            end
            `DCDIC_OFF_STATUS: begin
               st_next.rdata[`DCDIC_ST_MODE_MSB:`DCDIC_ST_MODE_LSB] = st_reg.mode;
               st_next.rdata[`DCDIC_ST_CSLAT_BIT] = st_reg.cs_lat;
               st_next.rdata[`DCDIC_ST_OVF_BIT] = st_reg.ovf;
               st_next.rdata[`DCDIC_ST_CNT_MSB:`DCDIC_ST_CNT_LSB] = pair_q.level;
            end
            `DCDIC_OFF_OUTPUT: begin
               st_next.rdata[`DCDIC_LO_MSB:`DCDIC_LO_LSB] = st_reg.out1;
               st_next.rdata[`DCDIC_HI_MSB:`DCDIC_HI_LSB] = st_reg.out2;
            end
            `DCDIC_OFF_LATCH: begin
               st_next.rdata[`DCDIC_LO_MSB:`DCDIC_LO_LSB] = st_reg.ch1_lat;
               st_next.rdata[`DCDIC_HI_MSB:`DCDIC_HI_LSB] = st_reg.ch2_lat;
            end
            default: begin
               st_next.rdata = '0;
            end
         endcase
      end
   end

   always_ff @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         st_reg <= '0;
         st_reg.mode <= dcdic_pkg::DCDIC_FULL_PD;
         st_reg.out1_c <= `DCDIC_CODE_MAX;
         st_reg.out2_c <= `DCDIC_CODE_MAX;
         st_reg.hold <= `DCDIC_CTRL_RST;
      end else if (I_CE) begin
         st_reg <= st_next;
      end
   end

   assign O_RDATA = st_reg.rdata;
   assign O_IOUT1 = st_reg.out1;
   assign O_IOUT1_C = st_reg.out1_c;
   assign O_IOUT2 = st_reg.out2;
   assign O_IOUT2_C = st_reg.out2_c;
   assign O_SEG1 = st_reg.seg1;
   assign O_SEG2 = st_reg.seg2;
   assign O_IOUT_EN = st_reg.iout_en;
   assign O_VOUT_EN = st_reg.vout_en;
   assign O_INT_CLK = st_reg.int_clk;
   assign O_MODE = st_reg.mode;
endmodule
`default_nettype wire

// file: test/dcdic_top_monitor.sv
// Concurrent checks on the top ports of the converter input control.
`include "dcdic_map.svh"
`default_nettype none
module dcdic_top_monitor (
   // Clock, reset and link
   input wire logic I_CLK,
   input wire logic I_RST,
   input wire logic I_CE,
   input wire logic I_CONV_CLK,
   // Mode pins
   input wire logic I_FULL_POWER_DOWN,
   input wire logic I_STANDBY_SELECT,
   input wire logic I_DEVICE_SELECT_N,
   input wire logic I_VOLTAGE_DAC_POWER_DOWN,
   // Converter outputs
   input wire logic [`DCDIC_CODE_W-1:0] O_IOUT1,
   input wire logic [`DCDIC_CODE_W-1:0] O_IOUT1_C,
   input wire logic [`DCDIC_CODE_W-1:0] O_IOUT2,
   input wire logic [`DCDIC_CODE_W-1:0] O_IOUT2_C,
   input wire logic [`DCDIC_SEG_W-1:0] O_SEG1,
   input wire logic [`DCDIC_SEG_W-1:0] O_SEG2,
   input wire logic O_IOUT_EN,
   input wire logic O_VOUT_EN,
   input wire logic O_INT_CLK,
   input wire logic [4:0] O_MODE
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge I_CLK); endclocking
   default disable iff (I_RST);
   logic conv_prev;
   logic sel_lat;
   logic vout_exp;
   logic frozen;
   function automatic logic [14:0] therm(input logic [3:0] c);
      for (int k = 0; k < 15; k++) therm[k] = (c > k);
   endfunction
   // The select latch only moves on a link rise, so a stopped link clock keeps it.
   always_ff @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         conv_prev <= 1'b0;
         sel_lat <= 1'b0;
      end else if (I_CE) begin
         conv_prev <= I_CONV_CLK;
         if (I_CONV_CLK && !conv_prev) sel_lat <= I_DEVICE_SELECT_N;
      end
   end
   assign vout_exp = !I_VOLTAGE_DAC_POWER_DOWN && !I_FULL_POWER_DOWN;
   // Standby and power-down stop the queue from draining, so no code or segment output may move in the next cycle.
   assign frozen = I_FULL_POWER_DOWN || !I_STANDBY_SELECT;
   a_comp_one: assert property (O_IOUT1_C == 12'hfff - O_IOUT1)
      else $error("channel 1 complement wrong");
   a_comp_two: assert property (O_IOUT2_C == 12'hfff - O_IOUT2)
      else $error("channel 2 complement wrong");
   a_seg_decode: assert property (O_SEG1 == therm(O_IOUT1[11:8]) && O_SEG2 == therm(O_IOUT2[11:8]))
      else $error("segment drive wrong");
   a_pd_tristate: assert property (I_CE && I_FULL_POWER_DOWN |=> !O_IOUT_EN && O_MODE == 5'h01)
      else $error("power-down mode wrong");
   a_standby_select_tristate: assert property (I_CE && !I_FULL_POWER_DOWN && !I_STANDBY_SELECT |=> !O_IOUT_EN)
      else $error("standby output driven");
   a_run_drive: assert property (I_CE && !I_FULL_POWER_DOWN && I_STANDBY_SELECT |=> O_IOUT_EN)
      else $error("running output not driven");
   a_vout_follow: assert property (I_CE |=> O_VOUT_EN == $past(vout_exp))
      else $error("voltage enable wrong");
   a_clk_follow: assert property (I_CE && !I_FULL_POWER_DOWN && !sel_lat |=> O_INT_CLK == $past(I_CONV_CLK))
      else $error("internal clock not following");
   a_clk_held: assert property (I_CE && (I_FULL_POWER_DOWN || sel_lat) |=> O_INT_CLK)
      else $error("internal clock not held high");
   a_out_frozen: assert property (I_CE && frozen |=> $stable(O_IOUT1) && $stable(O_IOUT2))
      else $error("outputs refreshed while frozen");
   c_normal: cover property (O_MODE == 5'h08 && $changed(O_IOUT1));
   c_standby_select: cover property (O_MODE == 5'h02);
   c_gated: cover property (O_MODE == 5'h04);
   c_hold: cover property (O_MODE == 5'h10);
endmodule
bind dcdic_top dcdic_top_monitor i_mon (
   .I_CLK(I_CLK),
   .I_RST(I_RST),
   .I_CE(I_CE),
   .I_CONV_CLK(I_CONV_CLK),
   .I_FULL_POWER_DOWN(I_FULL_POWER_DOWN),
   .I_STANDBY_SELECT(I_STANDBY_SELECT),
   .I_DEVICE_SELECT_N(I_DEVICE_SELECT_N),
   .I_VOLTAGE_DAC_POWER_DOWN(I_VOLTAGE_DAC_POWER_DOWN),
   .O_IOUT1(O_IOUT1),
   .O_IOUT1_C(O_IOUT1_C),
   .O_IOUT2(O_IOUT2),
   .O_IOUT2_C(O_IOUT2_C),
   .O_SEG1(O_SEG1),
   .O_SEG2(O_SEG2),
   .O_IOUT_EN(O_IOUT_EN),
   .O_VOUT_EN(O_VOUT_EN),
   .O_INT_CLK(O_INT_CLK),
   .O_MODE(O_MODE)
);
`default_nettype wire

// file: test/dcdic_host_model.sv
// Host model driving the conversion clock and the parallel data port.
`include "dcdic_map.svh"
`default_nettype none
module dcdic_host_model (
   // Clock
   input wire logic i_clk,
   // Conversion link
   output logic o_conv_clk,
   output logic [`DCDIC_CODE_W-1:0] o_data
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      o_conv_clk = 1'b0;
      o_data = 12'h5a5;
   end
   // word with edge.
   // The word stands one cycle only, then the bus shows its inverse so stale data never looks valid.
   task automatic edge_word(input logic lvl, input logic [`DCDIC_CODE_W-1:0] w);
      @(posedge i_clk);
      o_conv_clk <= lvl;
      o_data <= w;
      @(posedge i_clk);
      o_data <= ~w;
      repeat (5) @(posedge i_clk);
   endtask
   task automatic send_pair(input logic [11:0] a, input logic [11:0] b);
      edge_word(1'b1, a);
      edge_word(1'b0, b);
   endtask
endmodule
`default_nettype wire

// file: test/dual_current_dac_input_control_tb_top.sv
// Self-checking bench of the converter input control with a host model.
`include "dcdic_map.svh"
`default_nettype none
module dual_current_dac_input_control_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic I_CLK, I_RST, I_CE, I_CONV_CLK, I_WR, I_RD;
   logic I_FULL_POWER_DOWN, I_STANDBY_SELECT, I_DEVICE_SELECT_N, I_VOLTAGE_DAC_POWER_DOWN;
   logic [`DCDIC_CODE_W-1:0] I_DATA, O_IOUT1, O_IOUT1_C, O_IOUT2, O_IOUT2_C, w;
   logic [`DCDIC_SEG_W-1:0] O_SEG1, O_SEG2;
   logic [`DCDIC_ADDR_W-1:0] I_ADDR;
   logic [`DCDIC_DATA_W-1:0] I_WDATA, O_RDATA, rd;
   logic O_IOUT_EN, O_VOUT_EN, O_INT_CLK;
   logic [4:0] O_MODE;
   int mismatches, n_checks;
   dcdic_top i_dut (
      .I_CLK(I_CLK),
      .I_RST(I_RST),
      .I_CE(I_CE),
      .I_CONV_CLK(I_CONV_CLK),
      .I_DATA(I_DATA),
      .I_FULL_POWER_DOWN(I_FULL_POWER_DOWN),
      .I_STANDBY_SELECT(I_STANDBY_SELECT),
      .I_DEVICE_SELECT_N(I_DEVICE_SELECT_N),
      .I_VOLTAGE_DAC_POWER_DOWN(I_VOLTAGE_DAC_POWER_DOWN),
      .I_ADDR(I_ADDR),
      .I_WDATA(I_WDATA),
      .I_WR(I_WR),
      .I_RD(I_RD),
      .O_RDATA(O_RDATA),
      .O_IOUT1(O_IOUT1),
      .O_IOUT1_C(O_IOUT1_C),
      .O_IOUT2(O_IOUT2),
      .O_IOUT2_C(O_IOUT2_C),
      .O_SEG1(O_SEG1),
      .O_SEG2(O_SEG2),
      .O_IOUT_EN(O_IOUT_EN),
      .O_VOUT_EN(O_VOUT_EN),
      .O_INT_CLK(O_INT_CLK),
      .O_MODE(O_MODE)
   );
   dcdic_host_model i_host (.i_clk(I_CLK), .o_conv_clk(I_CONV_CLK), .o_data(I_DATA));
   initial begin
      I_CLK = 1'b0;
      forever #25 I_CLK = ~I_CLK;
   end
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic chk_out(input logic [11:0] e1, input logic [11:0] e2);
      #1;
      chk("iout1", 32'(e1), 32'(O_IOUT1));
      chk("iout2", 32'(e2), 32'(O_IOUT2));
      chk("iout1_c", 32'(12'hfff - e1), 32'(O_IOUT1_C));
      chk("iout2_c", 32'(12'hfff - e2), 32'(O_IOUT2_C));
   endtask
   task automatic chk_mode(input logic [4:0] m, input logic en, input logic ven);
      #1;
      chk("mode", 32'(m), 32'(O_MODE));
      chk("iout_en", 32'(en), 32'(O_IOUT_EN));
      chk("vout_en", 32'(ven), 32'(O_VOUT_EN));
   endtask
   task automatic pair(input logic [11:0] a, input logic [11:0] b, input logic [11:0] e1, input logic [11:0] e2);
      i_host.edge_word(1'b1, a);
      chk_out(e1, e2);
      i_host.edge_word(1'b0, b);
   endtask
   task automatic pins(input logic [3:0] p);
      @(posedge I_CLK);
      {I_FULL_POWER_DOWN, I_STANDBY_SELECT, I_DEVICE_SELECT_N, I_VOLTAGE_DAC_POWER_DOWN} <= p;
   endtask
   task automatic row(input logic [3:0] p, input logic [11:0] a, input logic [4:0] m, input logic en, input logic ven);
      pins(p);
      i_host.send_pair(a, ~a);
      chk_mode(m, en, ven);
   endtask
   task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge I_CLK);
      I_ADDR <= a;
      I_WDATA <= d;
      I_WR <= 1'b1;
      @(posedge I_CLK);
      I_WR <= 1'b0;
   endtask
   task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge I_CLK);
      I_ADDR <= a;
      I_RD <= 1'b1;
      @(posedge I_CLK);
      I_RD <= 1'b0;
      #1 d = O_RDATA;
   endtask
   task automatic close_out;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      repeat (5000) @(posedge I_CLK);
      mismatches++;
      close_out();
   end
   initial begin
      {I_RST, I_CE, I_WR, I_RD} = 4'hc;
      {I_FULL_POWER_DOWN, I_STANDBY_SELECT, I_DEVICE_SELECT_N, I_VOLTAGE_DAC_POWER_DOWN} = 4'h4;
      I_ADDR = 8'h00;
      I_WDATA = 32'h00000000;
      repeat (16) @(posedge I_CLK);
      I_RST <= 1'b0;
      row(4'h4, 12'h0aa, 5'h08, 1'b1, 1'b1);
      row(4'h3, 12'h0cc, 5'h04, 1'b0, 1'b0);
      row(4'h6, 12'h0ee, 5'h10, 1'b1, 1'b1);
      row(4'ha, 12'h0ab, 5'h01, 1'b0, 1'b0);
      $display("test modes done");
      pins(4'h4);
      i_host.send_pair(12'hfff, 12'h000);
      pair(12'h800, 12'h7ff, 12'h0cc, 12'h000);
      pair(12'hfff, 12'h000, 12'h800, 12'h7ff);
      pair(12'h123, 12'h456, 12'hfff, 12'h000);
      $display("test stream done");
      pins(4'h0);
      pair(12'h321, 12'h654, 12'hfff, 12'h000);
      chk_mode(5'h02, 1'b0, 1'b1);
      pair(12'h0f0, 12'h0e0, 12'hfff, 12'h000);
      pins(4'h4);
      repeat (3) @(posedge I_CLK);
      chk_out(12'hfff, 12'h000);
      pair(12'h111, 12'h222, 12'h0f0, 12'h0e0);
      $display("test standby done");
      reg_wr(8'h00, 32'h00000001);
      for (int i = 0; i < 10; i++) begin
         w = 12'h200 + 12'(i);
         i_host.send_pair(w, w + 12'h100);
      end
      reg_rd(8'h04, rd);
      chk("fifo full", 32'h00000840, rd & 32'h00000f40);
      chk_out(12'h0f0, 12'h0e0);
      reg_wr(8'h00, 32'h00000000);
      repeat (12) @(posedge I_CLK);
      chk_out(12'h206, 12'h306);
      reg_wr(8'h04, 32'h00000040);
      reg_rd(8'h04, rd);
      chk("fifo empty", 32'h00000000, rd & 32'h00000f40);
      // A full link transfer while the clock enable is low must leave the latches untouched.
      @(posedge I_CLK);
      I_CE <= 1'b0;
      i_host.send_pair(12'h7e7, 12'h7e7);
      @(posedge I_CLK);
      I_CE <= 1'b1;
      reg_rd(8'h0c, rd);
      chk("latches", 32'h03090209, rd);
      reg_rd(8'h10, rd);
      chk("unmapped", 32'h00000000, rd);
      reg_rd(8'h00, rd);
      chk("ctrl", 32'h00000000, rd);
      $display("test fifo done");
      close_out();
   end
endmodule
`default_nettype wire
